// file: dv/display_scan_driver_tb.sv
// Self-checking bench of the display scan driver: registers, pin enables and scan order.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module display_scan_driver_tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] wb_adr_i = 16'h0000;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_sel_i = 4'h1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic ext_clk_32k = 1'b0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, panel_type_select, lcd_bias_third;
    wire [7:0] com_out, p0_en, p1_en, p2_en;
    wire [23:0] seg_out;
    wire [3:0] lcd_voltage_code;
    wire [15:0] port_drive_level;
    wire [5:0] p5_en;
    int err_count = 0;
    int total_checks = 0;
    int slot_len, multi_hot;
    logic [7:0] rd;
    logic [1:0] c_duty [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    logic c_mux [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    int c_base [5] = '{0, 0, 0, 0, 4};
    int c_n [5] = '{8, 6, 5, 4, 4};
    int c_slot [5] = '{8, 8, 12, 16, 16};
    logic [23:0] c_seg [5] = '{24'h055555, 24'h155555, 24'h555555, 24'h555555, 24'h055555};
    logic [13:0] regs [8] = '{14'h0093, 14'h0094, 14'h0095, 14'h0096, 14'h0097, 14'h00a3, 14'h00db, 14'h008f};

    // Small divider values keep a whole frame down to under a hundred cycles.
    display_scan_driver #(.OSC_DIV_CYCLES(4), .TICKS_PER_FRAME(16)) u_display_scan_driver (
        .mclk(mclk), .rst(rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_ack_o(wb_ack_o), .ext_clk_32k(ext_clk_32k), .com_out(com_out), .seg_out(seg_out),
        .panel_type_select(panel_type_select), .lcd_bias_third(lcd_bias_third),
        .lcd_voltage_code(lcd_voltage_code), .port_drive_level(port_drive_level),
        .port0_display_enable(p0_en), .port1_display_enable(p1_en),
        .port2_display_enable(p2_en), .port5_display_enable(p5_en));
    panel_model u_panel_model (.mclk(mclk), .com_out(com_out), .seg_out(seg_out),
        .slot_len(slot_len), .multi_hot(multi_hot));

    initial
    begin
        forever #2.5 mclk = ~mclk;
    end
    // Free-running external scan source, one rising edge every six cycles.
    initial
    begin
        forever
        begin
            repeat (3) @(posedge mclk);
            ext_clk_32k <= ~ext_clk_32k;
        end
    end
    // =====================================================================
    // Bus and wait tasks
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic xfer(input logic [13:0] idx, input logic we, input logic [7:0] wd);
        int n;
        @(posedge mclk);
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h000000, wd};
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o[7:0];
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        if (n >= 50)
        begin
            err_count++;
            finish_test();
        end
    endtask
    task automatic settle;
        repeat (2) @(posedge mclk);
        #1;
    endtask
    // Waits for the next common, then one edge more so the panel has logged the slot.
    task automatic next_com;
        int n;
        logic [7:0] prev;
        prev = com_out;
        n = 0;
        while (com_out === prev && n < 200)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 200)
        begin
            err_count++;
            finish_test();
        end
        @(posedge mclk);
        #1;
    endtask
    // =====================================================================
    // Main sequence
    initial
    begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        foreach (regs[i])
        begin
            xfer(regs[i], 1'b0, 8'h00);
            `CHK("reset value", display_scan_pkg::REG_RESET, rd)
        end
        $display("test reset values done");
        xfer(display_scan_pkg::IDX_PORT1_OUT, 1'b1, 8'hff);
        xfer(display_scan_pkg::IDX_PORT1_OUT, 1'b0, 8'h00);
        `CHK("port1 reserved bits", 8'h3f, rd)
        xfer(display_scan_pkg::IDX_PORT5_OUT, 1'b1, 8'hff);
        xfer(display_scan_pkg::IDX_PORT5_OUT, 1'b0, 8'h00);
        `CHK("port5 reserved bits", 8'h3f, rd)
        xfer(display_scan_pkg::IDX_PORT1_OUT, 1'b1, 8'h21);
        xfer(display_scan_pkg::IDX_PORT5_OUT, 1'b1, 8'h06);
        xfer(display_scan_pkg::IDX_PORT0_OUT, 1'b1, 8'h5a);
        xfer(display_scan_pkg::IDX_PORT2_OUT, 1'b1, 8'ha5);
        xfer(display_scan_pkg::IDX_DRIVE0, 1'b1, 8'he4);
        xfer(display_scan_pkg::IDX_DRIVE1, 1'b1, 8'h1b);
        xfer(display_scan_pkg::IDX_CTRL, 1'b1, 8'h4a);
        xfer(display_scan_pkg::IDX_OUTCTL, 1'b1, 8'hff);
        xfer(display_scan_pkg::IDX_OUTCTL, 1'b0, 8'h00);
        `CHK("outctl readback", 8'h07, rd)
        xfer(14'h0001, 1'b0, 8'h00);
        `CHK("unmapped read", 8'h00, rd)
        settle();
        `CHK("port1 pins", 8'h83, p1_en)
        `CHK("port5 pins", 6'h04, p5_en)
        `CHK("port0 pins", 8'h5a, p0_en)
        `CHK("port2 pins", 8'ha5, p2_en)
        `CHK("drive levels", 16'h1be4, port_drive_level)
        `CHK("led mode", 1'b1, panel_type_select)
        `CHK("voltage code", 4'ha, lcd_voltage_code)
        `CHK("third bias", 1'b1, lcd_bias_third)
        xfer(display_scan_pkg::IDX_OUTCTL, 1'b1, 8'h00);
        xfer(display_scan_pkg::IDX_CTRL, 1'b1, 8'h00);
        settle();
        `CHK("quarter bias", 1'b0, lcd_bias_third)
        `CHK("lcd mode", 1'b0, panel_type_select)
        $display("test registers done");
        for (int k = 0; k < 24; k++)
            xfer(display_scan_pkg::IDX_MEM_BASE + 14'(k), 1'b1, k[0] ? 8'h00 : 8'hff);
        xfer(display_scan_pkg::IDX_MEM_LAST - 14'h0001, 1'b0, 8'h00);
        `CHK("memory byte", 8'hff, rd)
        for (int c = 0; c < 5; c++)
        begin
            xfer(display_scan_pkg::IDX_CTRL, 1'b1, 8'h00);
            xfer(display_scan_pkg::IDX_OUTCTL, 1'b1, {6'h00, c_mux[c], 1'b0});
            settle();
            `CHK("stopped commons", 8'h00, com_out)
            `CHK("stopped segments", 24'h000000, seg_out)
            xfer(display_scan_pkg::IDX_CTRL, 1'b1, {2'h3, c_duty[c], 4'h0});
            @(posedge mclk);
            #1;
            `CHK("first common", 8'h01 << c_base[c], com_out)
            // The free-running divider cuts the first slot short, so slots are timed from the second.
            next_com();
            for (int i = 2; i <= c_n[c] + 1; i++)
            begin
                next_com();
                `CHK("common order", 8'h01 << (c_base[c] + i % c_n[c]), com_out)
                `CHK("segments", c_seg[c], seg_out)
                `CHK("slot length", c_slot[c], slot_len)
            end
            $display("test scan config %0d done", c);
        end
        `CHK("single common", 0, multi_hot)
        xfer(display_scan_pkg::IDX_CTRL, 1'b1, 8'h00);
        xfer(display_scan_pkg::IDX_OUTCTL, 1'b1, 8'h00);
        xfer(display_scan_pkg::IDX_CTRL, 1'b1, 8'hb0);
        settle();
        repeat (4) next_com();
        `CHK("lcd inverted commons", 8'h0e, com_out)
        `CHK("lcd inverted segments", 24'haaaaaa, seg_out)
        $display("test lcd frame inversion done");
        xfer(display_scan_pkg::IDX_CTRL, 1'b1, 8'h00);
        xfer(display_scan_pkg::IDX_OUTCTL, 1'b1, 8'h04);
        xfer(display_scan_pkg::IDX_CTRL, 1'b1, 8'hf0);
        settle();
        repeat (2) next_com();
        `CHK("external source slot", 24, slot_len)
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        settle();
        `CHK("reset commons", 8'h00, com_out)
        `CHK("reset port0 pins", 8'h00, p0_en)
        `CHK("reset drive levels", 16'h0000, port_drive_level)
        $display("test external source and mid-run reset done");
        finish_test();
    end
endmodule

// file: dv/panel_model.sv
// Behavioural panel: watches the common lines and measures how long each common stands.
`timescale 1ns/1ps
module panel_model (
    input wire logic mclk, // System clock.
    input wire logic [7:0] com_out, // Common lines from the driver.
    input wire logic [23:0] seg_out, // Segment lines, observed only.
    output int slot_len, // Cycles the previous common stood.
    output int multi_hot // Cycles with more than one common driven.
);
    logic [7:0] last_com = 8'h00;
    int run = 0;
    initial slot_len = 0;
    initial multi_hot = 0;
    // =====================================================================
    // Line watch
    // Two commons at once would light a whole row of the glass twice.
    always @(posedge mclk)
    begin
        if ($countones(com_out) > 1)
            multi_hot <= multi_hot + 1;
        if (com_out !== last_com)
        begin
            slot_len <= run + 1;
            run <= 0;
        end
        else
            run <= run + 1;
        last_com <= com_out;
    end
endmodule

// file: include/display_scan_pkg.sv
// Register map, field layout and timing constants of the display scan driver.
package display_scan_pkg;
    // =====================================================================
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [13:0] IDX_PORT1_OUT = 14'h0093;
    localparam logic [13:0] IDX_PORT0_OUT = 14'h0094;
    localparam logic [13:0] IDX_CTRL = 14'h0095;
    localparam logic [13:0] IDX_DRIVE0 = 14'h0096;
    localparam logic [13:0] IDX_DRIVE1 = 14'h0097;
    localparam logic [13:0] IDX_STATUS = 14'h009f;
    localparam logic [13:0] IDX_PORT2_OUT = 14'h00a3;
    localparam logic [13:0] IDX_PORT5_OUT = 14'h00db;
    localparam logic [13:0] IDX_OUTCTL = 14'h008f;
    localparam logic [13:0] IDX_MEM_BASE = 14'h0f00;
    localparam logic [13:0] IDX_MEM_LAST = 14'h0f17;
    localparam int unsigned MEM_BYTES = 24;
    localparam int unsigned NUM_COMS = 8;
    // =====================================================================
    // Field positions and reset values.
    localparam int unsigned CTRL_EN_BIT = 7;
    localparam int unsigned CTRL_MODE_BIT = 6;
    localparam int unsigned CTRL_DUTY_LSB = 4;
    localparam int unsigned OUTCTL_BIAS_BIT = 0;
    localparam int unsigned OUTCTL_MUX_BIT = 1;
    localparam int unsigned OUTCTL_CLKSEL_BIT = 2;
    localparam int unsigned STATUS_PHASE_BIT = 3;
    localparam int unsigned STATUS_RUN_BIT = 4;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] NARROW_PORT_MASK = 8'h3f;
    localparam logic [7:0] OUTCTL_MASK = 8'h07;
    localparam logic [1:0] DUTY_EIGHTH = 2'h0;
    localparam logic [1:0] DUTY_SIXTH = 2'h1;
    localparam logic [1:0] DUTY_FIFTH = 2'h2;
    localparam logic [1:0] DUTY_QUARTER = 2'h3;
    // =====================================================================
    // Timing: system clock period and the 32 kHz scan source.
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned LOW_OSC_PERIOD_PS = 31250000;
    localparam int unsigned LOW_OSC_CYCLES = LOW_OSC_PERIOD_PS / CLK_PERIOD_PS;
    localparam int unsigned LOW_OSC_HZ = 32000;
    localparam int unsigned FRAME_HZ = 64;
    localparam int unsigned TICKS_PER_FRAME = LOW_OSC_HZ / FRAME_HZ;
endpackage

// file: verilog/display_scan_driver.sv
// LCD/LED common and segment scan driver with its Wishbone register file.
//
// Overview of operation
// [R01] One panel mode: bit clear LCD, set LED.
// [R02] Enable bit stops or runs continuous scanning.
// [R03] Duty 00: 1/8, S0-S19, C0-C7.
// [R04] Duty 01: 1/6, S0-S21, C0-C5.
// [R05] Duty 10: 1/5, S0-S22, C0-C4.
// [R06] Duty 11: 1/4, two segment/common splits.
// [R07] Multiplex bit picks S0-S23/C0-C3 or S0-S19/C4-C7.
// [R08] Internal or external 32 kHz source, ~64 Hz frame.
// [R09] Same pins and registers; mode picks waveform.
// [R10] LCD offers 1/4 and 1/3 bias.
// [R11] Bias bit clear 1/4, set 1/3.
// [R12] Four drive strengths via nibble fields.
// [R13] Drive code 00 strongest, 11 weakest.
// [R14] Port0 enable bits hand pins to display.
// [R15] Port1 bits 5-0 map pins 7,6,5,4,3,0.
// [R16] Port2 enable bits map pins one-to-one.
// [R17] Port5 bits 5-2 pins; bits 1,0 port1.
// [R18] Voltage code steps 1/32 from 17/32; fields reset zero.
// [R19] One memory byte per segment; bit k common k.
// [R20] Commons take equal slots; segments show that bit.
`timescale 1ns/1ps
module display_scan_driver #(
    parameter int unsigned OSC_DIV_CYCLES = display_scan_pkg::LOW_OSC_CYCLES,
    parameter int unsigned TICKS_PER_FRAME = display_scan_pkg::TICKS_PER_FRAME
) (
    input wire logic mclk, // System clock, 200 MHz.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic [15:0] wb_adr_i, // Wishbone byte address.
    input wire logic [31:0] wb_dat_i, // Wishbone write data.
    output logic [31:0] wb_dat_o, // Wishbone read data.
    input wire logic wb_we_i, // Wishbone write enable.
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
    input wire logic wb_cyc_i, // Wishbone cycle.
    input wire logic wb_stb_i, // Wishbone strobe.
    output logic wb_ack_o, // Wishbone acknowledge.
    input wire logic ext_clk_32k, // External 32 kHz oscillator, sampled.
    output logic [7:0] com_out, // Common line levels.
    output logic [23:0] seg_out, // Segment line levels.
    output logic panel_type_select, // High for LED waveforms.
    output logic lcd_bias_third, // High selects 1/3 bias.
    output logic [3:0] lcd_voltage_code, // Drive voltage code.
    output logic [15:0] port_drive_level, // Nibble drive levels, ports 0,1,2,5.
    output logic [7:0] port0_display_enable, // Port-0 pins owned by display.
    output logic [7:0] port1_display_enable, // Port-1 pins owned by display.
    output logic [7:0] port2_display_enable, // Port-2 pins owned by display.
    output logic [5:0] port5_display_enable // Port-5 pins owned by display.
);
    // =====================================================================
    // Parameter checks.
    // Refused at elaboration: the divider counter is 16 bits wide and the slot counter 8 bits.
    if (OSC_DIV_CYCLES < 2 || OSC_DIV_CYCLES > 65535)
    begin : g_bad_div
        $error("OSC_DIV_CYCLES out of range");
    end
    if (TICKS_PER_FRAME < 8 || TICKS_PER_FRAME / 4 > 255)
    begin : g_bad_frame
        $error("TICKS_PER_FRAME out of range");
    end

    // =====================================================================
    // State.
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] outctl;
        logic [7:0] drive0;
        logic [7:0] drive1;
        logic [7:0] port0;
        logic [7:0] port1;
        logic [7:0] port2;
        logic [7:0] port5;
        logic [23:0][7:0] mem;
        logic ack;
        logic [31:0] rdat;
        logic [15:0] div_cnt;
        logic ext_q;
        logic [7:0] tick_cnt;
        logic [2:0] com_idx;
        logic phase;
        logic [7:0] com_out;
        logic [23:0] seg_out;
    } state_type;

    state_type state;
    state_type next_state;

    // =====================================================================
    // Geometry of each duty setting.
    function automatic logic [3:0] com_count(input logic [1:0] duty);
        case (duty)
            display_scan_pkg::DUTY_EIGHTH: com_count = 4'h8; // see [R03]
            display_scan_pkg::DUTY_SIXTH: com_count = 4'h6; // see [R04]
            display_scan_pkg::DUTY_FIFTH: com_count = 4'h5; // see [R05]
            default: com_count = 4'h4; // see [R06]
        endcase
    endfunction

    function automatic logic [4:0] seg_count(input logic [1:0] duty, input logic mux);
        case (duty)
            display_scan_pkg::DUTY_EIGHTH: seg_count = 5'h14; // see [R03]
            display_scan_pkg::DUTY_SIXTH: seg_count = 5'h16; // see [R04]
            display_scan_pkg::DUTY_FIFTH: seg_count = 5'h17; // see [R05]
            default: seg_count = mux ? 5'h14 : 5'h18; // see [R07]
        endcase
    endfunction

    function automatic logic [2:0] com_base(input logic [1:0] duty, input logic mux);
        com_base = (duty == display_scan_pkg::DUTY_QUARTER && mux) ? 3'h4 : 3'h0; // see [R07]
    endfunction

    // Slot length in scan ticks; integer division keeps every slot equal.
    function automatic logic [7:0] slot_len(input logic [1:0] duty);
        slot_len = 8'(TICKS_PER_FRAME / int'(com_count(duty))); // see [R20]
    endfunction

    // =====================================================================
    // Register decode views.
    logic [13:0] idx;
    logic req;
    logic scan_en;
    logic led_mode;
    logic [1:0] duty;
    logic mux_sel;
    logic tick;
    logic [2:0] pcom;

    assign idx = wb_adr_i[15:2];
    assign req = wb_cyc_i && wb_stb_i && !state.ack;
    assign scan_en = state.ctrl[display_scan_pkg::CTRL_EN_BIT];
    assign led_mode = state.ctrl[display_scan_pkg::CTRL_MODE_BIT];
    assign duty = state.ctrl[display_scan_pkg::CTRL_DUTY_LSB +: 2];
    assign mux_sel = state.outctl[display_scan_pkg::OUTCTL_MUX_BIT];
    assign pcom = 3'(com_base(duty, mux_sel) + state.com_idx);
    // The external source is taken as synchronous, so one stored sample suffices for its edge.
    assign tick = state.outctl[display_scan_pkg::OUTCTL_CLKSEL_BIT] ? (ext_clk_32k && !state.ext_q)
                : (state.div_cnt == 16'(OSC_DIV_CYCLES - 1)); // see [R08]

    // =====================================================================
    // Next-state logic.
    always_comb
    begin
        logic [7:0] com_vec;
        logic [7:0] com_mask;
        logic [23:0] seg_vec;
        logic [31:0] rd;
        com_vec = 8'h00;
        com_mask = 8'h00;
        seg_vec = 24'h000000;
        rd = 32'h00000000;
        next_state = state;
        next_state.ack = 1'b0;

        // Bus slave: one registered acknowledge per request; unmapped reads return zero.
        if (req)
        begin
            next_state.ack = 1'b1;
            case (idx)
                display_scan_pkg::IDX_CTRL: rd[7:0] = state.ctrl;
                display_scan_pkg::IDX_OUTCTL: rd[7:0] = state.outctl;
                display_scan_pkg::IDX_DRIVE0: rd[7:0] = state.drive0;
                display_scan_pkg::IDX_DRIVE1: rd[7:0] = state.drive1;
                display_scan_pkg::IDX_PORT0_OUT: rd[7:0] = state.port0;
                display_scan_pkg::IDX_PORT1_OUT: rd[7:0] = state.port1;
                display_scan_pkg::IDX_PORT2_OUT: rd[7:0] = state.port2;
                display_scan_pkg::IDX_PORT5_OUT: rd[7:0] = state.port5;
                display_scan_pkg::IDX_STATUS:
                begin
                    rd[2:0] = state.com_idx;
                    rd[display_scan_pkg::STATUS_PHASE_BIT] = state.phase;
                    rd[display_scan_pkg::STATUS_RUN_BIT] = scan_en;
                end
                default:
                begin
                    if (idx >= display_scan_pkg::IDX_MEM_BASE && idx <= display_scan_pkg::IDX_MEM_LAST)
                        rd[7:0] = state.mem[5'(idx - display_scan_pkg::IDX_MEM_BASE)]; // see [R19]
                end
            endcase
            next_state.rdat = rd;
            if (wb_we_i && wb_sel_i[0])
            begin
                case (idx)
                    display_scan_pkg::IDX_CTRL: next_state.ctrl = wb_dat_i[7:0]; // see [R01]
                    display_scan_pkg::IDX_OUTCTL:
                        next_state.outctl = wb_dat_i[7:0] & display_scan_pkg::OUTCTL_MASK; // see [R11]
                    display_scan_pkg::IDX_DRIVE0: next_state.drive0 = wb_dat_i[7:0]; // see [R12]
                    display_scan_pkg::IDX_DRIVE1: next_state.drive1 = wb_dat_i[7:0]; // see [R13]
                    display_scan_pkg::IDX_PORT0_OUT: next_state.port0 = wb_dat_i[7:0]; // see [R14]
                    display_scan_pkg::IDX_PORT1_OUT:
                        next_state.port1 = wb_dat_i[7:0] & display_scan_pkg::NARROW_PORT_MASK; // see [R15]
                    display_scan_pkg::IDX_PORT2_OUT: next_state.port2 = wb_dat_i[7:0]; // see [R16]
                    display_scan_pkg::IDX_PORT5_OUT:
                        next_state.port5 = wb_dat_i[7:0] & display_scan_pkg::NARROW_PORT_MASK; // see [R17]
                    default:
                    begin
                        if (idx >= display_scan_pkg::IDX_MEM_BASE && idx <= display_scan_pkg::IDX_MEM_LAST)
                            next_state.mem[5'(idx - display_scan_pkg::IDX_MEM_BASE)] = wb_dat_i[7:0];
                    end
                endcase
            end
        end

        // Scan source divider runs free so that the tick rate never depends on scan state.
        next_state.ext_q = ext_clk_32k;
        if (state.div_cnt >= 16'(OSC_DIV_CYCLES - 1))
            next_state.div_cnt = 16'h0000;
        else
            next_state.div_cnt = 16'(state.div_cnt + 16'h0001);

        if (!scan_en)
        begin
            // Scan stopped: every line rests low and the sequence restarts at index zero, which is C0, or C4 in 1/4 duty with the multiplex bit set.
            next_state.tick_cnt = 8'h00; // see [R02]
            next_state.com_idx = 3'h0;
            next_state.phase = 1'b0;
            next_state.com_out = 8'h00;
            next_state.seg_out = 24'h000000;
        end
        else
        begin
            if (tick)
            begin
                if (state.tick_cnt >= 8'(slot_len(duty) - 8'h01))
                begin
                    next_state.tick_cnt = 8'h00;
                    // A duty change mid-frame can leave the index past the end; >= wraps it.
                    if (4'(state.com_idx) >= 4'(com_count(duty) - 4'h1))
                    begin
                        next_state.com_idx = 3'h0;
                        next_state.phase = !state.phase; // see [R20]
                    end
                    else
                        next_state.com_idx = 3'(state.com_idx + 3'h1);
                end
                else
                    next_state.tick_cnt = 8'(state.tick_cnt + 8'h01);
            end
            for (int c = 0; c < display_scan_pkg::NUM_COMS; c++)
            begin
                if (c >= int'(com_base(duty, mux_sel)) &&
                    c < int'(com_base(duty, mux_sel)) + int'(com_count(duty)))
                    com_mask[c] = 1'b1;
            end
            com_vec[pcom] = 1'b1;
            for (int k = 0; k < display_scan_pkg::MEM_BYTES; k++)
            begin
                if (k < int'(seg_count(duty, mux_sel)))
                    seg_vec[k] = state.mem[k][pcom]; // see [R19]
            end
            // LED lines are plain active-high levels; LCD lines invert every other frame
            // so the glass sees no net DC, which the bias network then shapes.
            if (led_mode)
            begin
                next_state.com_out = com_vec; // see [R09]
                next_state.seg_out = seg_vec;
            end
            else
            begin
                next_state.com_out = (com_vec ^ {8{state.phase}}) & com_mask; // see [R09]
                next_state.seg_out = seg_vec ^ ({24{state.phase}} & ((24'h000001 << seg_count(duty, mux_sel)) - 24'h000001));
            end
        end
    end

    // =====================================================================
    // State register.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state <= '0; // see [R18]
        end
        else
        begin
            state <= next_state;
        end
    end

    // =====================================================================
    // Outputs.
    assign wb_ack_o = state.ack;
    assign wb_dat_o = state.rdat;
    assign com_out = state.com_out;
    assign seg_out = state.seg_out;
    assign panel_type_select = led_mode; // see [R01]
    assign lcd_bias_third = state.outctl[display_scan_pkg::OUTCTL_BIAS_BIT]; // see [R10]
    assign lcd_voltage_code = state.ctrl[3:0]; // see [R18]
    assign port_drive_level = {state.drive1, state.drive0}; // see [R12]
    assign port0_display_enable = state.port0; // see [R14]
    assign port1_display_enable = {state.port1[5:2], state.port1[1], state.port5[0], state.port5[1],
                                   state.port1[0]}; // see [R15]
    assign port2_display_enable = state.port2; // see [R16]
    assign port5_display_enable = {state.port5[5:2], 2'b00}; // see [R17]

    // =====================================================================
    // Assertions.
    sequence s_write(logic [13:0] target);
        wb_cyc_i && wb_stb_i && !state.ack && wb_we_i && wb_sel_i[0] && idx == target;
    endsequence

    property p_bus_ack;
        @(posedge mclk) disable iff (rst)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_bus_ack: assert property (p_bus_ack) else $error("ack not given one cycle after request");

    // The second stopped cycle is checked because the lines lag the enable bit by one register.
    property p_scan_off;
        @(posedge mclk) disable iff (rst)
        !scan_en [*2] |-> com_out == 8'h00 && seg_out == 24'h000000;
    endproperty
    a_scan_off: assert property (p_scan_off) else $error("lines active while scan off"); // see [R02]

    property p_led_one_common;
        @(posedge mclk) disable iff (rst)
        (scan_en && led_mode) [*2] |-> $onehot(com_out);
    endproperty
    a_led_one_common: assert property (p_led_one_common) else $error("LED mode not one common"); // see [R01]

    property p_eighth;
        @(posedge mclk) disable iff (rst)
        (scan_en && duty == display_scan_pkg::DUTY_EIGHTH) |=> seg_out[23:20] == 4'h0;
    endproperty
    a_eighth: assert property (p_eighth) else $error("1/8 duty drives S20-S23"); // see [R03]

    property p_sixth;
        @(posedge mclk) disable iff (rst)
        (scan_en && duty == display_scan_pkg::DUTY_SIXTH) |=> com_out[7:6] == 2'h0 && seg_out[23:22] == 2'h0;
    endproperty
    a_sixth: assert property (p_sixth) else $error("1/6 duty drives unused lines"); // see [R04]

    property p_fifth;
        @(posedge mclk) disable iff (rst)
        (scan_en && duty == display_scan_pkg::DUTY_FIFTH) |=> com_out[7:5] == 3'h0 && !seg_out[23];
    endproperty
    a_fifth: assert property (p_fifth) else $error("1/5 duty drives unused lines"); // see [R05]

    // The split is judged against the multiplex bit that produced the lines, one cycle back.
    property p_quarter_split;
        @(posedge mclk) disable iff (rst)
        (scan_en && duty == display_scan_pkg::DUTY_QUARTER) |=>
            ($past(mux_sel) ? (com_out[3:0] == 4'h0 && seg_out[23:20] == 4'h0) : com_out[7:4] == 4'h0);
    endproperty
    a_quarter_split: assert property (p_quarter_split) else $error("1/4 duty split wrong"); // see [R07]

    property p_tick_period;
        @(posedge mclk) disable iff (rst)
        (!state.outctl[display_scan_pkg::OUTCTL_CLKSEL_BIT] && tick) |=> state.div_cnt == 16'h0000;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("internal tick period wrong"); // see [R08]

    property p_slot_advance;
        @(posedge mclk) disable iff (rst)
        (scan_en && $stable(state.ctrl) && tick && state.tick_cnt == 8'(slot_len(duty) - 8'h01))
            |=> state.com_idx != $past(state.com_idx) || com_count(duty) == 4'h1;
    endproperty
    a_slot_advance: assert property (p_slot_advance) else $error("common did not advance"); // see [R20]

    property p_port1_map;
        @(posedge mclk) disable iff (rst)
        s_write(display_scan_pkg::IDX_PORT1_OUT) ##1 wb_ack_o |-> ##1
            port1_display_enable[7] == $past(wb_dat_i[5], 2) && port1_display_enable[0] == $past(wb_dat_i[0], 2);
    endproperty
    a_port1_map: assert property (p_port1_map) else $error("port-1 enable mapping wrong"); // see [R15]

    property p_reset_clear;
        @(posedge mclk) $fell(rst) |-> lcd_voltage_code == 4'h0 && !scan_en && port0_display_enable == 8'h00;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("field not zero after reset"); // see [R18]
endmodule
